// [common/fcc_pkg.sv]
package fcc_pkg;
    // field positions in the configuration byte
    localparam int unsigned FCC_BIT_DUTY_SRC = 5;
    localparam int unsigned FCC_BIT_FIX0 = 4;
    localparam int unsigned FCC_BIT_FIX1 = 3;
    localparam int unsigned FCC_BIT_PPR_HI = 2;
    localparam int unsigned FCC_BIT_PPR_LO = 1;
    localparam int unsigned FCC_BIT_SHUTDOWN = 0;

    // reset values of the writable fields
    localparam logic FCC_RST_DUTY_SRC = 1'h0;
    localparam logic [1:0] FCC_RST_PPR = 2'h1;
    localparam logic FCC_RST_SHUTDOWN = 1'h0;
    // constant readback of the unused bits
    localparam logic FCC_FIX0_VAL = 1'h0;
    localparam logic FCC_FIX1_VAL = 1'h1;
    // decoded pulses-per-rev counts
    localparam logic [3:0] FCC_PPR_CNT_ONE = 4'h1;
    localparam logic [3:0] FCC_PPR_CNT_TWO = 4'h2;
    localparam logic [3:0] FCC_PPR_CNT_FOUR = 4'h4;
    localparam logic [3:0] FCC_PPR_CNT_EIGHT = 4'h8;

    // temperature input in millivolts, duty in hundredths of a percent
    localparam int unsigned FCC_MV_W = 12;
    localparam int unsigned FCC_DUTY_W = 14;
    localparam logic [11:0] FCC_MV_LOW = 12'h654;     // 1620 mV
    localparam logic [11:0] FCC_MV_HIGH = 12'ha28;    // 2600 mV
    localparam logic [13:0] FCC_DUTY_MIN = 14'h0bb8;  // 30.00 %
    localparam logic [13:0] FCC_DUTY_MAX = 14'h2710;  // 100.00 %
    localparam logic [13:0] FCC_DUTY_OPEN = 14'h0f5d; // 39.33 %
    // slope: 7000 duty steps over 980 mV is 50/7 per mV
    localparam logic [19:0] FCC_SLOPE_NUM = 20'h00032;
    localparam logic [19:0] FCC_SLOPE_DEN = 20'h00007;

    typedef enum logic [1:0] {
        FCC_PPR_ONE,
        FCC_PPR_TWO,
        FCC_PPR_FOUR,
        FCC_PPR_EIGHT
    } fcc_ppr_t;

    // writable configuration fields
    typedef struct packed {
        logic duty_source_select;
        fcc_ppr_t pulses_per_rev_select;
        logic shutdown_select;
    } fcc_cfg_t;

    // temperature sample from the converter
    typedef struct packed {
        logic open;
        logic [11:0] mv;
    } fcc_temp_t;
endpackage

// [logic/fcc_config.sv]
`timescale 1ns/10ps
module fcc_config
    import fcc_pkg::*;
#(
    parameter int unsigned CNT_W = 16
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic cfg_wr,
    input wire logic [7:0] cfg_wdata,
    output logic [5:0] cfg_rdata,
    input wire logic [13:0] duty_setpoint,
    input wire fcc_temp_t temp_in,
    input wire logic pulse_cnt_valid,
    input wire logic [CNT_W-1:0] pulse_cnt,
    output logic [13:0] duty_out,
    output logic [3:0] pulses_per_rev,
    output logic shutdown,
    output logic [CNT_W-1:0] rev_cnt,
    output logic rev_cnt_valid
);
    // readback value during and right after reset; bit order follows the field positions
    localparam logic [5:0] RDATA_RST = {FCC_RST_DUTY_SRC, FCC_FIX0_VAL, FCC_FIX1_VAL,
                                        FCC_RST_PPR, FCC_RST_SHUTDOWN};

    // stored configuration fields
    fcc_cfg_t cfg_q;
    fcc_cfg_t cfg_d;
    // readback image of bits 5..0
    logic [5:0] rdata_q;
    logic [5:0] rdata_d;
    // selected duty, hundredths of a percent
    logic [13:0] duty_q;
    logic [13:0] duty_d;
    // decoded pulses per revolution
    logic [3:0] ppr_q;
    logic [3:0] ppr_d;
    // revolution count and its one-cycle valid
    logic [CNT_W-1:0] rev_q;
    logic [CNT_W-1:0] rev_d;
    logic rev_vld_q;
    logic rev_vld_d;
    // analog curve helpers
    logic [19:0] span;
    logic [19:0] scaled;
    logic [19:0] analog_duty;
    logic analog_low;
    logic analog_high;

    // host write of the configuration fields; bits 7, 6, 4 and 3 of the byte are dropped here
    always_comb begin
        cfg_d = cfg_q;
        if (cfg_wr) begin
            cfg_d.duty_source_select = cfg_wdata[FCC_BIT_DUTY_SRC];
            cfg_d.pulses_per_rev_select = fcc_ppr_t'(cfg_wdata[FCC_BIT_PPR_HI:FCC_BIT_PPR_LO]);
            cfg_d.shutdown_select = cfg_wdata[FCC_BIT_SHUTDOWN];
        end
    end

    // configuration register; reset gives analog mode, two pulses per rev, running
    always_ff @(posedge clk) begin
        if (rst) begin
            cfg_q.duty_source_select <= FCC_RST_DUTY_SRC;
            cfg_q.pulses_per_rev_select <= fcc_ppr_t'(FCC_RST_PPR);
            cfg_q.shutdown_select <= FCC_RST_SHUTDOWN;
        end else begin
            cfg_q <= cfg_d;
        end
    end

    // readback image, rebuilt each cycle from the stored fields
    always_comb begin
        rdata_d = '0;
        rdata_d[FCC_BIT_DUTY_SRC] = cfg_q.duty_source_select;
        rdata_d[FCC_BIT_FIX0] = FCC_FIX0_VAL;
        rdata_d[FCC_BIT_FIX1] = FCC_FIX1_VAL;
        rdata_d[FCC_BIT_PPR_HI:FCC_BIT_PPR_LO] = cfg_q.pulses_per_rev_select;
        rdata_d[FCC_BIT_SHUTDOWN] = cfg_q.shutdown_select;
    end

    // readback register; one edge behind the fields, so a read right after a write sees the old byte
    always_ff @(posedge clk) begin
        if (rst) begin
            // fixed bits hold during reset too
            rdata_q <= RDATA_RST;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    // linear part of the analog curve; the difference may wrap below the low point,
    // but it is only taken strictly between the two clamp points
    always_comb begin
        analog_low = (temp_in.mv <= FCC_MV_LOW);
        analog_high = (temp_in.mv >= FCC_MV_HIGH);
        span = {8'h00, temp_in.mv - FCC_MV_LOW};
        scaled = (span * FCC_SLOPE_NUM) / FCC_SLOPE_DEN;
        analog_duty = {6'h00, FCC_DUTY_MIN} + scaled;
    end

    // duty source selection; the setpoint passes unchecked, the host keeps it in range
    always_comb begin
        duty_d = FCC_DUTY_MIN;
        if (cfg_q.duty_source_select) begin
            duty_d = duty_setpoint;
        end else if (temp_in.open) begin
            duty_d = FCC_DUTY_OPEN;
        end else if (analog_low) begin
            duty_d = FCC_DUTY_MIN;
        end else if (analog_high) begin
            duty_d = FCC_DUTY_MAX;
        end else begin
            duty_d = analog_duty[13:0];
        end
    end

    // duty register; reset shows the open-input startup duty
    always_ff @(posedge clk) begin
        if (rst) begin
            duty_q <= FCC_DUTY_OPEN;
        end else begin
            duty_q <= duty_d;
        end
    end

    // decode of the pulses-per-rev field
    always_comb begin
        case (cfg_q.pulses_per_rev_select)
            FCC_PPR_ONE: ppr_d = FCC_PPR_CNT_ONE;
            FCC_PPR_TWO: ppr_d = FCC_PPR_CNT_TWO;
            FCC_PPR_FOUR: ppr_d = FCC_PPR_CNT_FOUR;
            FCC_PPR_EIGHT: ppr_d = FCC_PPR_CNT_EIGHT;
            default: ppr_d = FCC_PPR_CNT_TWO;
        endcase
    end

    // decoded count register, reset to the count of the default field value
    always_ff @(posedge clk) begin
        if (rst) begin
            ppr_q <= FCC_PPR_CNT_TWO;
        end else begin
            ppr_q <= ppr_d;
        end
    end

    // revolutions from pulses; powers of two keep this a shift, no divider, remainder dropped
    always_comb begin
        rev_d = rev_q;
        rev_vld_d = pulse_cnt_valid;
        if (pulse_cnt_valid) begin
            rev_d = pulse_cnt >> cfg_q.pulses_per_rev_select;
        end
    end

    // revolution count holds between updates; valid follows pulse_cnt_valid one cycle later
    always_ff @(posedge clk) begin
        if (rst) begin
            rev_q <= '0;
            rev_vld_q <= 1'h0;
        end else begin
            rev_q <= rev_d;
            rev_vld_q <= rev_vld_d;
        end
    end

    // outputs straight from the registers
    assign cfg_rdata = rdata_q;
    assign duty_out = duty_q;
    assign pulses_per_rev = ppr_q;
    // low-power shutdown level; only flagged, the drive stages act on it
    assign shutdown = cfg_q.shutdown_select;
    assign rev_cnt = rev_q;
    assign rev_cnt_valid = rev_vld_q;
endmodule // fcc_config

// [tb/fcc_config_tb.sv]
`timescale 1ns/10ps
module fcc_config_tb;
    logic clk = 1'h0, rst = 1'h1, pulse_cnt_valid = 1'h0, cfg_wr, shutdown, rev_cnt_valid;
    logic [13:0] duty_setpoint = 14'h04d2, duty_out;
    fcc_pkg::fcc_temp_t temp_in = 13'h1000;
    logic [15:0] pulse_cnt = 16'h03e8, rev_cnt;
    logic [7:0] cfg_wdata;
    logic [5:0] cfg_rdata;
    logic [3:0] pulses_per_rev;
    logic [12:0] mv[3] = '{13'h0654, 13'h076c, 13'h0a28};
    logic [15:0] du[3] = '{16'h0bb8, 16'h1388, 16'h2710};
    int error_cnt = 0, total_checks = 0;
    always #2.5 clk = ~clk;
    fcc_host i_fcc_host (
        .clk(clk),
        .cfg_wr(cfg_wr),
        .cfg_wdata(cfg_wdata)
    );
    fcc_config i_fcc_config (
        .clk(clk),
        .rst(rst),
        .cfg_wr(cfg_wr),
        .cfg_wdata(cfg_wdata),
        .cfg_rdata(cfg_rdata),
        .duty_setpoint(duty_setpoint),
        .temp_in(temp_in),
        .pulse_cnt_valid(pulse_cnt_valid),
        .pulse_cnt(pulse_cnt),
        .duty_out(duty_out),
        .pulses_per_rev(pulses_per_rev),
        .shutdown(shutdown),
        .rev_cnt(rev_cnt),
        .rev_cnt_valid(rev_cnt_valid)
    );
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic conclude();
        if (error_cnt == 0 && total_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // reset defaults, analog mapping, host mode, then every pulse count
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'h0;
        wt(2);
        chk(cfg_rdata, 16'h0a);
        chk(pulses_per_rev, 16'h2);
        chk(duty_out, 16'h0f5d);
        for (int i = 0; i < 3; i++) begin
            @(posedge clk);
            temp_in <= mv[i];
            wt(2);
            chk(duty_out, du[i]);
        end
        i_fcc_host.write(8'hff);
        wt(2);
        chk(cfg_rdata, 16'h2f);
        chk(shutdown, 16'h1);
        chk(duty_out, 16'h04d2);
        // bit 4 set on purpose: it must never reach the readback
        for (int k = 0; k < 4; k++) begin
            i_fcc_host.write(8'h10 | 8'(k << 1));
            @(posedge clk);
            pulse_cnt_valid <= 1'h1;
            @(posedge clk);
            pulse_cnt_valid <= 1'h0;
            #1;
            chk(rev_cnt_valid, 16'h1);
            chk(rev_cnt, 16'h03e8 >> k);
            wt(1);
            chk(rev_cnt_valid, 16'h0);
            chk(cfg_rdata, 16'h08 | 16'(k << 1));
            chk(pulses_per_rev, 16'h1 << k);
            chk(rev_cnt, 16'h03e8 >> k);
            chk(shutdown, 16'h0);
            chk(duty_out, 16'h2710);
        end
        // mid-run reset from a non-default state
        i_fcc_host.write(8'h21);
        #1;
        chk(shutdown, 16'h1);
        @(posedge clk);
        rst <= 1'h1;
        repeat (2) @(posedge clk);
        rst <= 1'h0;
        wt(2);
        chk(cfg_rdata, 16'h0a);
        chk(pulses_per_rev, 16'h2);
        chk(shutdown, 16'h0);
        chk(rev_cnt, 16'h0);
        chk(duty_out, 16'h2710);
        conclude();
    end
    // hang guard, well beyond the roughly sixty cycles the tests need
    initial begin
        #20000;
        error_cnt++;
        conclude();
    end
endmodule // fcc_config_tb

// [tb/fcc_host.sv]
`timescale 1ns/10ps
module fcc_host (
    input wire logic clk,
    output logic cfg_wr = 1'h0,
    output logic [7:0] cfg_wdata = 8'h00
);
    // one strobe per byte; data inverted after release so stale bytes never match
    task automatic write(input logic [7:0] d);
        @(posedge clk);
        cfg_wr <= 1'h1;
        cfg_wdata <= d;
        @(posedge clk);
        cfg_wr <= 1'h0;
        cfg_wdata <= ~d;
    endtask
endmodule // fcc_host

// [tb/fcc_props.sv]
`timescale 1ns/10ps
module fcc_props
    import fcc_pkg::*;
#(
    parameter int unsigned CNT_W = 16
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic cfg_wr,
    input wire logic [7:0] cfg_wdata,
    input wire logic [5:0] cfg_rdata,
    input wire logic [13:0] duty_setpoint,
    input wire fcc_temp_t temp_in,
    input wire logic pulse_cnt_valid,
    input wire logic [CNT_W-1:0] pulse_cnt,
    input wire logic [13:0] duty_out,
    input wire logic [3:0] pulses_per_rev,
    input wire logic shutdown,
    input wire logic [CNT_W-1:0] rev_cnt,
    input wire logic rev_cnt_valid
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // readback lags the fields by one edge, just as the outputs other than shutdown do
    property p_hd; cfg_rdata[5] |-> duty_out == $past(duty_setpoint); endproperty
    a_hd: assert property (p_hd) else $error("duty not from setpoint");
    property p_hi; !$past(rst) && !cfg_rdata[5] && !$past(temp_in.open) && $past(temp_in.mv) >= FCC_MV_HIGH
        |-> duty_out == FCC_DUTY_MAX; endproperty
    a_hi: assert property (p_hi) else $error("duty at top of range");
    property p_op; !cfg_rdata[5] && $past(temp_in.open) |-> duty_out == FCC_DUTY_OPEN; endproperty
    a_op: assert property (p_op) else $error("duty with open input");
    property p_pp; !$past(rst) |-> pulses_per_rev == 4'h1 << cfg_rdata[2:1]; endproperty
    a_pp: assert property (p_pp) else $error("pulses per rev decode");
    property p_rc; $past(pulse_cnt_valid) && !$past(rst)
        |-> rev_cnt_valid && rev_cnt == $past(pulse_cnt) / pulses_per_rev; endproperty
    a_rc: assert property (p_rc) else $error("revolution count");
    property p_rv; !$past(pulse_cnt_valid) |-> !rev_cnt_valid; endproperty
    a_rv: assert property (p_rv) else $error("revolution valid without count");
    property p_sd; cfg_wr |=> shutdown == $past(cfg_wdata[0]); endproperty
    a_sd: assert property (p_sd) else $error("shutdown flag");
    property p_fx; !$past(rst) |-> cfg_rdata[4:3] == 2'h1; endproperty
    a_fx: assert property (p_fx) else $error("fixed bits");
endmodule // fcc_props
bind fcc_config fcc_props #(.CNT_W(CNT_W)) i_fcc_props (
    .clk(clk),
    .rst(rst),
    .cfg_wr(cfg_wr),
    .cfg_wdata(cfg_wdata),
    .cfg_rdata(cfg_rdata),
    .duty_setpoint(duty_setpoint),
    .temp_in(temp_in),
    .pulse_cnt_valid(pulse_cnt_valid),
    .pulse_cnt(pulse_cnt),
    .duty_out(duty_out),
    .pulses_per_rev(pulses_per_rev),
    .shutdown(shutdown),
    .rev_cnt(rev_cnt),
    .rev_cnt_valid(rev_cnt_valid)
);
